// file: mdsr_defines.vh
`ifndef MDSR_DEFINES_VH
`define MDSR_DEFINES_VH

// clock rate and register update period
`define MDSR_CLK_MHZ            250
`define MDSR_UPDATE_PERIOD_NS   100000
// update period in clock cycles: 100000 ns at 250 MHz
`define MDSR_UPDATE_CYCLES      24'h0061a8

// frame layout: seven 16-bit words, msb first
`define MDSR_FRAME_BITS         7'h70
`define MDSR_FLAG_WRITE         16'h0001
`define MDSR_FLAG_READ          16'h0000
`define MDSR_FAIL_ADDR          16'h0000
`define MDSR_FAIL_DATA          32'h7cf0bdc2

// register addresses
`define MDSR_ADDR_X_SRC         16'h4000
`define MDSR_ADDR_X_MODE        16'h4002
`define MDSR_ADDR_Y_SRC         16'h4005
`define MDSR_ADDR_Y_MODE        16'h4007
`define MDSR_ADDR_X_SET         16'h5000
`define MDSR_ADDR_Y_SET         16'h5100
`define MDSR_ADDR_X_UNIT        16'h6000
`define MDSR_ADDR_X_RUN         16'h6001
`define MDSR_ADDR_X_SHAPE       16'h6002
`define MDSR_ADDR_X_FREQ        16'h6003
`define MDSR_ADDR_X_AMP         16'h6004
`define MDSR_ADDR_Y_UNIT        16'h6100
`define MDSR_ADDR_Y_RUN         16'h6101
`define MDSR_ADDR_Y_SHAPE       16'h6102
`define MDSR_ADDR_Y_FREQ        16'h6103
`define MDSR_ADDR_Y_AMP         16'h6104

// storage word indices
`define MDSR_IDX_X_SRC          4'h0
`define MDSR_IDX_X_MODE         4'h1
`define MDSR_IDX_Y_SRC          4'h2
`define MDSR_IDX_Y_MODE         4'h3
`define MDSR_IDX_X_SET          4'h4
`define MDSR_IDX_Y_SET          4'h5
`define MDSR_IDX_X_UNIT         4'h6
`define MDSR_IDX_X_RUN          4'h7
`define MDSR_IDX_X_SHAPE        4'h8
`define MDSR_IDX_X_FREQ         4'h9
`define MDSR_IDX_X_AMP          4'ha
`define MDSR_IDX_Y_UNIT         4'hb
`define MDSR_IDX_Y_RUN          4'hc
`define MDSR_IDX_Y_SHAPE        4'hd
`define MDSR_IDX_Y_FREQ         4'he
`define MDSR_IDX_Y_AMP          4'hf

// register codes
`define MDSR_SRC_STATIC         32'h00000000
`define MDSR_SRC_X_GEN          32'h00000060
`define MDSR_SRC_Y_GEN          32'h00000061
`define MDSR_SRC_X_ANA          32'h00000058
`define MDSR_SRC_Y_ANA          32'h00000059
`define MDSR_MODE_X_CL          32'h000000c0
`define MDSR_MODE_X_OL          32'h000000b0
`define MDSR_MODE_Y_CL          32'h000000c1
`define MDSR_MODE_Y_OL          32'h000000b1
`define MDSR_UNIT_XY            32'h00000002
`define MDSR_UNIT_CURRENT       32'h00000000
`define MDSR_SHAPE_TRI          32'h00000001
`define MDSR_SHAPE_SIN          32'h00000000
`define MDSR_RUN_ON             32'h00000001
`define MDSR_WORD_ZERO          32'h00000000

// decoded source select encoding
`define MDSR_SRCSEL_STATIC      2'h0
`define MDSR_SRCSEL_GEN         2'h1
`define MDSR_SRCSEL_ANALOG      2'h2

`endif

// file: mdsr_regfile.v
`timescale 1ns/1ps
`include "mdsr_defines.vh"

module mdsr_regfile
(
   input  wire         i_mclk,
   input  wire         i_reset_n,
   input  wire         i_wr_en,
   input  wire [3:0]   i_wr_idx,
   input  wire [31:0]  i_wr_data,
   input  wire [3:0]   i_rd_idx,
   output reg  [31:0]  o_rd_data,
   output wire [511:0] o_words
);

   // reset value of each word: open loop modes, static sources, rest zero
   function [31:0] reset_val;
      input [3:0] idx;
      begin
         case (idx)
            `MDSR_IDX_X_MODE: reset_val = `MDSR_MODE_X_OL;
            `MDSR_IDX_Y_MODE: reset_val = `MDSR_MODE_Y_OL;
            `MDSR_IDX_X_SRC:  reset_val = `MDSR_SRC_STATIC;
            `MDSR_IDX_Y_SRC:  reset_val = `MDSR_SRC_STATIC;
            default:          reset_val = `MDSR_WORD_ZERO;
         endcase
      end
   endfunction

   reg [31:0] mem_reg [0:15];

   // one flop word per register, kept until rewritten or reset
   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1)
      begin : g_word
         localparam [31:0] WORD_IDX = g;
         always @(posedge i_mclk)
         begin
            if (!i_reset_n)
               mem_reg[g] <= reset_val(WORD_IDX[3:0]);
            else if (i_wr_en && (i_wr_idx == WORD_IDX[3:0]))
               mem_reg[g] <= i_wr_data;
         end
         assign o_words[g*32 +: 32] = mem_reg[g];
      end
   endgenerate

   // registered read port
   always @(posedge i_mclk)
   begin
      if (!i_reset_n)
         o_rd_data <= `MDSR_WORD_ZERO;
      else
         o_rd_data <= mem_reg[i_rd_idx];
   end

endmodule // mdsr_regfile

// file: mdsr_spi_regs.v
`timescale 1ns/1ps
`include "mdsr_defines.vh"


module mdsr_spi_regs
#(
   parameter [23:0] UPDATE_CYCLES = `MDSR_UPDATE_CYCLES
)
(
   input  wire        i_mclk,
   input  wire        i_reset_n,
   input  wire        i_spi_sclk,
   input  wire        i_spi_mosi,
   input  wire        i_spi_nss_n,
   output reg         o_spi_miso,
   output reg         o_frame_processing_flag,
   input  wire [31:0] i_x_readback,
   input  wire [31:0] i_y_readback,
   input  wire        i_readback_ok,
   output reg  [1:0]  o_x_source_sel,
   output reg  [1:0]  o_y_source_sel,
   output reg         o_x_closed_loop,
   output reg         o_y_closed_loop,
   output reg         o_x_unit_xy,
   output reg         o_y_unit_xy,
   output reg         o_x_shape_tri,
   output reg         o_y_shape_tri,
   output reg         o_x_gen_run,
   output reg         o_y_gen_run,
   output reg  [31:0] o_x_setpoint,
   output reg  [31:0] o_y_setpoint,
   output reg  [31:0] o_x_gen_freq,
   output reg  [31:0] o_y_gen_freq,
   output reg  [31:0] o_x_gen_amp,
   output reg  [31:0] o_y_gen_amp
);

   localparam [5:0] ST_IDLE = 6'h01;
   localparam [5:0] ST_RECV = 6'h02;
   localparam [5:0] ST_WR1  = 6'h04;
   localparam [5:0] ST_WR2  = 6'h08;
   localparam [5:0] ST_WAIT = 6'h10;
   localparam [5:0] ST_LOAD = 6'h20;

   // map a register address to {valid, index}
   function [4:0] addr_decode;
      input [15:0] a;
      begin
         case (a)
            `MDSR_ADDR_X_SRC:   addr_decode = {1'b1, `MDSR_IDX_X_SRC};
            `MDSR_ADDR_Y_SRC:   addr_decode = {1'b1, `MDSR_IDX_Y_SRC};
            `MDSR_ADDR_X_MODE:  addr_decode = {1'b1, `MDSR_IDX_X_MODE};
            `MDSR_ADDR_Y_MODE:  addr_decode = {1'b1, `MDSR_IDX_Y_MODE};
            `MDSR_ADDR_X_SET:   addr_decode = {1'b1, `MDSR_IDX_X_SET};
            `MDSR_ADDR_Y_SET:   addr_decode = {1'b1, `MDSR_IDX_Y_SET};
            `MDSR_ADDR_X_UNIT:  addr_decode = {1'b1, `MDSR_IDX_X_UNIT};
            `MDSR_ADDR_Y_UNIT:  addr_decode = {1'b1, `MDSR_IDX_Y_UNIT};
            `MDSR_ADDR_X_RUN:   addr_decode = {1'b1, `MDSR_IDX_X_RUN};
            `MDSR_ADDR_Y_RUN:   addr_decode = {1'b1, `MDSR_IDX_Y_RUN};
            `MDSR_ADDR_X_SHAPE: addr_decode = {1'b1, `MDSR_IDX_X_SHAPE};
            `MDSR_ADDR_Y_SHAPE: addr_decode = {1'b1, `MDSR_IDX_Y_SHAPE};
            `MDSR_ADDR_X_FREQ:  addr_decode = {1'b1, `MDSR_IDX_X_FREQ};
            `MDSR_ADDR_Y_FREQ:  addr_decode = {1'b1, `MDSR_IDX_Y_FREQ};
            `MDSR_ADDR_X_AMP:   addr_decode = {1'b1, `MDSR_IDX_X_AMP};
            `MDSR_ADDR_Y_AMP:   addr_decode = {1'b1, `MDSR_IDX_Y_AMP};
            default:            addr_decode = 5'h00;
         endcase
      end
   endfunction

   // map a source selector word to the decoded source
   function [1:0] src_decode;
      input [31:0] v;
      input [31:0] gen_code;
      input [31:0] ana_code;
      begin
         if (v == gen_code)
            src_decode = `MDSR_SRCSEL_GEN;
         else if (v == ana_code)
            src_decode = `MDSR_SRCSEL_ANALOG;
         else
            src_decode = `MDSR_SRCSEL_STATIC;
      end
   endfunction

   // pin synchronisers: sclk, mosi, nss
   reg  [2:0]   sync1_reg;
   reg  [2:0]   sync2_reg;
   reg  [2:0]   sync3_reg;
   reg  [2:0]   filt_reg;
   reg  [2:0]   filt_d_reg;
   wire [2:0]   pin_in;

   // frame engine
   reg  [5:0]   state_reg;
   reg  [6:0]   bit_cnt_reg;
   reg  [111:0] rx_reg;
   reg  [111:0] tx_reg;
   reg  [111:0] resp_reg;
   reg  [23:0]  timer_reg;
   reg  [15:0]  flag_word_reg;
   reg          ok1_reg;
   reg          ok2_reg;
   reg          rd_ok_reg;

   // register storage port
   reg          wr_en;
   reg  [3:0]   wr_idx;
   reg  [31:0]  wr_data;
   wire [31:0]  rd_data;
   wire [511:0] words;

   wire [4:0]   dec1;
   wire [4:0]   dec2;
   wire         sclk_rise;
   wire         sclk_fall;
   wire         nss_fall;
   wire         nss_rise;
   wire         is_write;
   wire         is_read;
   wire [31:0]  rb_x;
   wire [31:0]  rb_y;

   assign pin_in    = {i_spi_nss_n, i_spi_mosi, i_spi_sclk};
   assign sclk_rise = filt_reg[0] & ~filt_d_reg[0];
   assign sclk_fall = ~filt_reg[0] & filt_d_reg[0];
   assign nss_fall  = ~filt_reg[2] & filt_d_reg[2];
   assign nss_rise  = filt_reg[2] & ~filt_d_reg[2];
   assign dec1      = addr_decode(rx_reg[95:80]);
   assign dec2      = addr_decode(rx_reg[79:64]);
   assign is_write  = (rx_reg[111:96] == `MDSR_FLAG_WRITE);
   assign is_read   = (rx_reg[111:96] == `MDSR_FLAG_READ);
   assign rb_x      = i_readback_ok ? i_x_readback : `MDSR_FAIL_DATA;
   assign rb_y      = i_readback_ok ? i_y_readback : `MDSR_FAIL_DATA;

   // three-flop sampling, a level counts once stages two and three agree
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : g_sync
         always @(posedge i_mclk)
         begin
            if (!i_reset_n)
            begin
               sync1_reg[g]  <= (g == 2) ? 1'b1 : 1'b0;
               sync2_reg[g]  <= (g == 2) ? 1'b1 : 1'b0;
               sync3_reg[g]  <= (g == 2) ? 1'b1 : 1'b0;
               filt_reg[g]   <= (g == 2) ? 1'b1 : 1'b0;
               filt_d_reg[g] <= (g == 2) ? 1'b1 : 1'b0;
            end
            else
            begin
               sync1_reg[g]  <= pin_in[g];
               sync2_reg[g]  <= sync1_reg[g];
               sync3_reg[g]  <= sync2_reg[g];
               if (sync2_reg[g] == sync3_reg[g])
                  filt_reg[g] <= sync3_reg[g];
               filt_d_reg[g] <= filt_reg[g];
            end
         end
      end
   endgenerate

   // storage write selection: first pair in WR1, second pair in WR2
   always @*
   begin
      wr_en   = 1'b0;
      wr_idx  = dec1[3:0];
      wr_data = rx_reg[63:32];
      if ((state_reg == ST_WR1) && is_write && dec1[4])
         wr_en = 1'b1;
      else if ((state_reg == ST_WR2) && is_write && dec2[4])
      begin
         wr_en   = 1'b1;
         wr_idx  = dec2[3:0];
         wr_data = rx_reg[31:0];
      end
   end

   mdsr_regfile u_regfile
   (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .i_wr_en   (wr_en),
      .i_wr_idx  (wr_idx),
      .i_wr_data (wr_data),
      .i_rd_idx  (dec1[3:0]),
      .o_rd_data (rd_data),
      .o_words   (words)
   );

   // frame engine: receive, apply, hold for the update period, build reply
   always @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         state_reg               <= ST_IDLE;
         bit_cnt_reg             <= 7'h00;
         rx_reg                  <= 112'h0;
         tx_reg                  <= 112'h0;
         resp_reg                <= {`MDSR_FLAG_WRITE, `MDSR_FAIL_ADDR, `MDSR_FAIL_ADDR,
                                     `MDSR_FAIL_DATA, `MDSR_FAIL_DATA};
         timer_reg               <= 24'h000000;
         flag_word_reg           <= `MDSR_FLAG_WRITE;
         ok1_reg                 <= 1'b0;
         ok2_reg                 <= 1'b0;
         rd_ok_reg               <= 1'b0;
         o_spi_miso              <= 1'b0;
         o_frame_processing_flag <= 1'b0;
      end
      else
      begin
         if (timer_reg != 24'hffffff)
            timer_reg <= timer_reg + 24'h000001;
         case (state_reg)
            ST_IDLE:
            begin
               if (nss_fall)
               begin
                  state_reg               <= ST_RECV;
                  o_frame_processing_flag <= 1'b1;
                  bit_cnt_reg             <= 7'h00;
                  timer_reg               <= 24'h000000;
                  tx_reg                  <= resp_reg;
               end
            end
            ST_RECV:
            begin
               // master shifts on rise, we sample on fall, msb first
               if (sclk_fall)
               begin
                  rx_reg <= {rx_reg[110:0], filt_reg[1]};
                  if (bit_cnt_reg != 7'h7f)
                     bit_cnt_reg <= bit_cnt_reg + 7'h01;
               end
               if (sclk_rise)
               begin
                  o_spi_miso <= tx_reg[111];
                  tx_reg     <= {tx_reg[110:0], 1'b0};
               end
               if (nss_rise)
               begin
                  if (bit_cnt_reg == `MDSR_FRAME_BITS)
                     state_reg <= ST_WR1;
                  else
                     state_reg <= ST_WAIT; // short or long frame is dropped
               end
            end
            ST_WR1:
            begin
               flag_word_reg <= rx_reg[111:96];
               ok1_reg       <= dec1[4];
               state_reg     <= ST_WR2;
            end
            ST_WR2:
            begin
               ok2_reg   <= dec2[4];
               rd_ok_reg <= is_read & dec1[4];
               state_reg <= ST_WAIT;
            end
            ST_WAIT:
            begin
               // registers are already written in WR1 and WR2; the reply waits here until the update period counted from the select fall has run out
               if (timer_reg >= UPDATE_CYCLES)
                  state_reg <= ST_LOAD;
            end
            ST_LOAD:
            begin
               // a dropped frame leaves the previous reply in place
               if (bit_cnt_reg != `MDSR_FRAME_BITS)
                  resp_reg <= resp_reg;
               else if (flag_word_reg == `MDSR_FLAG_WRITE)
                  resp_reg <= {flag_word_reg,
                               ok1_reg ? rx_reg[95:80] : `MDSR_FAIL_ADDR,
                               ok2_reg ? rx_reg[79:64] : `MDSR_FAIL_ADDR,
                               rb_x, rb_y};
               else
                  resp_reg <= {flag_word_reg,
                               rd_ok_reg ? rd_data : `MDSR_FAIL_DATA,
                               rb_x, rb_y};
               o_frame_processing_flag <= 1'b0;
               state_reg               <= ST_IDLE;
            end
            default:
            begin
               state_reg               <= ST_IDLE;
               o_frame_processing_flag <= 1'b0;
            end
         endcase
      end
   end

   // decoded configuration outputs, registered
   always @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         o_x_source_sel  <= `MDSR_SRCSEL_STATIC;
         o_y_source_sel  <= `MDSR_SRCSEL_STATIC;
         o_x_closed_loop <= 1'b0;
         o_y_closed_loop <= 1'b0;
         o_x_unit_xy     <= 1'b0;
         o_y_unit_xy     <= 1'b0;
         o_x_shape_tri   <= 1'b0;
         o_y_shape_tri   <= 1'b0;
         o_x_gen_run     <= 1'b0;
         o_y_gen_run     <= 1'b0;
         o_x_setpoint    <= `MDSR_WORD_ZERO;
         o_y_setpoint    <= `MDSR_WORD_ZERO;
         o_x_gen_freq    <= `MDSR_WORD_ZERO;
         o_y_gen_freq    <= `MDSR_WORD_ZERO;
         o_x_gen_amp     <= `MDSR_WORD_ZERO;
         o_y_gen_amp     <= `MDSR_WORD_ZERO;
      end
      else
      begin
         o_x_source_sel  <= src_decode(words[0*32 +: 32], `MDSR_SRC_X_GEN, `MDSR_SRC_X_ANA);
         o_y_source_sel  <= src_decode(words[2*32 +: 32], `MDSR_SRC_Y_GEN, `MDSR_SRC_Y_ANA);
         o_x_closed_loop <= (words[1*32 +: 32] == `MDSR_MODE_X_CL);
         o_y_closed_loop <= (words[3*32 +: 32] == `MDSR_MODE_Y_CL);
         o_x_unit_xy     <= (words[6*32 +: 32] == `MDSR_UNIT_XY);
         o_y_unit_xy     <= (words[11*32 +: 32] == `MDSR_UNIT_XY);
         o_x_shape_tri   <= (words[8*32 +: 32] == `MDSR_SHAPE_TRI);
         o_y_shape_tri   <= (words[13*32 +: 32] == `MDSR_SHAPE_TRI);
         o_x_gen_run     <= (words[7*32 +: 32] == `MDSR_RUN_ON);
         o_y_gen_run     <= (words[12*32 +: 32] == `MDSR_RUN_ON);
         o_x_setpoint    <= words[4*32 +: 32];
         o_y_setpoint    <= words[5*32 +: 32];
         o_x_gen_freq    <= words[9*32 +: 32];
         o_y_gen_freq    <= words[14*32 +: 32];
         o_x_gen_amp     <= words[10*32 +: 32];
         o_y_gen_amp     <= words[15*32 +: 32];
      end
   end

endmodule // mdsr_spi_regs

// file: mdsr_spi_regs_asserts.sv
`timescale 1ns/1ps
`include "mdsr_defines.vh"

module mdsr_spi_regs_asserts
#(
   parameter [23:0] UPDATE_CYCLES = 24'h61a8
)
(
   input wire logic        i_mclk,
   input wire logic        i_reset_n,
   input wire logic        i_spi_sclk,
   input wire logic        i_spi_nss_n,
   input wire logic        o_spi_miso,
   input wire logic        o_frame_processing_flag,
   input wire logic [1:0]  o_x_source_sel,
   input wire logic [1:0]  o_y_source_sel,
   input wire logic        o_x_closed_loop,
   input wire logic        o_y_closed_loop,
   input wire logic [31:0] o_x_setpoint,
   input wire logic [31:0] o_x_gen_freq
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);

   // cycles the processing flag has been high
   logic [23:0] busy_cnt;
   always_ff @(posedge i_mclk)
      if (!i_reset_n || !o_frame_processing_flag)
         busy_cnt <= 24'h0;
      else
         busy_cnt <= busy_cnt + 24'h1;

   // frame start seen while idle, then flag raised shortly after
   sequence frame_start;
      $fell(i_spi_nss_n) ##0 !o_frame_processing_flag;
   endsequence
   sequence flag_up;
      ##[1:8] o_frame_processing_flag;
   endsequence

   flag_rise_a: assert property (frame_start |-> flag_up)
      else $error("processing flag not raised after select fell");
   flag_hold_a: assert property ($fell(o_frame_processing_flag) |-> busy_cnt >= UPDATE_CYCLES - 24'h2)
      else $error("processing flag fell before the update period");
   flag_end_a: assert property ($fell(o_frame_processing_flag) |-> i_spi_nss_n && $past(i_spi_nss_n, 3))
      else $error("processing flag fell before the frame ended");
   flag_frame_a: assert property (o_frame_processing_flag && !i_spi_nss_n |=> o_frame_processing_flag)
      else $error("processing flag dropped inside a frame");
   reset_defaults_a: assert property ($rose(i_reset_n) |-> o_x_source_sel == `MDSR_SRCSEL_STATIC
      && o_y_source_sel == `MDSR_SRCSEL_STATIC && !o_x_closed_loop && !o_y_closed_loop)
      else $error("configuration not at defaults after reset");
   miso_hold_a: assert property ($fell(i_spi_sclk) && !i_spi_nss_n |=> $stable(o_spi_miso) [*8])
      else $error("reply bit changed during low clock phase");
   x_cfg_hold_a: assert property ($changed({o_x_setpoint, o_x_gen_freq}) |-> i_spi_nss_n)
      else $error("x configuration changed inside a frame");
   y_cfg_hold_a: assert property ($changed({o_y_source_sel, o_y_closed_loop}) |-> i_spi_nss_n)
      else $error("y configuration changed inside a frame");
endmodule // mdsr_spi_regs_asserts

bind mdsr_spi_regs mdsr_spi_regs_asserts #(.UPDATE_CYCLES(UPDATE_CYCLES)) mdsr_spi_regs_asserts_inst
(
   .i_mclk                  (i_mclk),
   .i_reset_n               (i_reset_n),
   .i_spi_sclk              (i_spi_sclk),
   .i_spi_nss_n             (i_spi_nss_n),
   .o_spi_miso              (o_spi_miso),
   .o_frame_processing_flag (o_frame_processing_flag),
   .o_x_source_sel          (o_x_source_sel),
   .o_y_source_sel          (o_y_source_sel),
   .o_x_closed_loop         (o_x_closed_loop),
   .o_y_closed_loop         (o_y_closed_loop),
   .o_x_setpoint            (o_x_setpoint),
   .o_x_gen_freq            (o_x_gen_freq)
);

// file: mdsr_spi_master.sv
`timescale 1ns/1ps

module mdsr_spi_master
(
   output logic o_sclk,
   output logic o_mosi,
   output logic o_nss_n,
   input  wire  i_miso
);
   // idle: clock still and low, nothing selected
   initial
   begin
      o_sclk  = 1'b0;
      o_mosi  = 1'b0;
      o_nss_n = 1'b1;
   end

   // mode 1 frame of 112 bits msb first, reply taken at each falling edge
   task automatic xfer(input logic [111:0] tx, output logic [111:0] rx);
      int i;
      o_nss_n = 1'b0;
      #80;                  // select well ahead of the first clock edge
      for (i = 111; i >= 0; i--)
      begin
         o_sclk = 1'b1;
         o_mosi = tx[i];
         #80;
         o_sclk = 1'b0;
         rx[i]  = i_miso;
         #80;
      end
      o_nss_n = 1'b1;
      o_mosi  = ~tx[0];     // released line shows no stale value
   endtask
endmodule // mdsr_spi_master

// file: tb.sv
`timescale 1ns/1ps
`include "mdsr_defines.vh"

module tb;
   localparam int UPD = 200;
   logic         i_mclk, i_reset_n, rb_ok;
   logic [31:0]  x_rb, y_rb;
   logic [111:0] exp_rx;
   wire          sclk, mosi, nss_n, miso, flag;
   wire  [1:0]   x_src, y_src;
   wire          x_cl, y_cl, x_xy, y_xy, x_tri, y_tri, x_run, y_run;
   wire  [31:0]  x_set, y_set, x_frq, y_frq, x_amp, y_amp;
   int           failures, cmp_count;

   mdsr_spi_master mdsr_spi_master_inst (.o_sclk(sclk), .o_mosi(mosi), .o_nss_n(nss_n), .i_miso(miso));

   mdsr_spi_regs #(.UPDATE_CYCLES(UPD)) mdsr_spi_regs_inst
   (
      .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_spi_sclk(sclk), .i_spi_mosi(mosi), .i_spi_nss_n(nss_n),
      .o_spi_miso(miso), .o_frame_processing_flag(flag), .i_x_readback(x_rb), .i_y_readback(y_rb),
      .i_readback_ok(rb_ok), .o_x_source_sel(x_src), .o_y_source_sel(y_src), .o_x_closed_loop(x_cl),
      .o_y_closed_loop(y_cl), .o_x_unit_xy(x_xy), .o_y_unit_xy(y_xy), .o_x_shape_tri(x_tri),
      .o_y_shape_tri(y_tri), .o_x_gen_run(x_run), .o_y_gen_run(y_run), .o_x_setpoint(x_set),
      .o_y_setpoint(y_set), .o_x_gen_freq(x_frq), .o_y_gen_freq(y_frq), .o_x_gen_amp(x_amp),
      .o_y_gen_amp(y_amp)
   );

   // 250 MHz clock
   initial
   begin
      i_mclk = 1'b0;
      forever #2 i_mclk = ~i_mclk;
   end

   // compare and count
   task automatic chk(input string name, input logic [111:0] exp, input logic [111:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // verdict and end of run
   task automatic results();
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // reset for 8 cycles, then defaults at the ports
   task automatic do_reset();
      i_reset_n = 1'b0;
      repeat (8) @(posedge i_mclk);
      #1 i_reset_n = 1'b1;
      @(posedge i_mclk);
      #1;
      exp_rx = {`MDSR_FLAG_WRITE, 32'h0, `MDSR_FAIL_DATA, `MDSR_FAIL_DATA};
      chk("x source", `MDSR_SRCSEL_STATIC, x_src);
      chk("y source", `MDSR_SRCSEL_STATIC, y_src);
      chk("loops", 2'h0, {x_cl, y_cl});
      chk("x setpoint", 32'h0, x_set);
      chk("flag", 1'b0, flag);
   endtask

   // one frame; its reply carries the previous frame's result, nxt is the reply it leaves
   task automatic xact(input logic [111:0] tx, input logic [111:0] nxt);
      logic [111:0] rx;
      int n;
      mdsr_spi_master_inst.xfer(tx, rx);
      chk("reply", exp_rx, rx);
      exp_rx = nxt;
      @(posedge i_mclk);
      #1;
      chk("flag busy", 1'b1, flag);
      for (n = 0; n < 2 * UPD && flag !== 1'b0; n++)
         @(posedge i_mclk);
      if (flag !== 1'b0)
      begin
         failures++;
         $display("CHECK FAILED flag release expected 0 seen %b", flag);
         results();
      end
      repeat (4) @(posedge i_mclk);
      #1;
   endtask

   // one write frame and the reply it leaves behind
   task automatic frame(input logic [15:0] a1, a2, input logic [31:0] d1, d2, input logic ok1);
      logic [111:0] nxt;
      nxt = {`MDSR_FLAG_WRITE, ok1 ? a1 : `MDSR_FAIL_ADDR, a2, rb_ok ? x_rb : `MDSR_FAIL_DATA,
             rb_ok ? y_rb : `MDSR_FAIL_DATA};
      xact({`MDSR_FLAG_WRITE, a1, a2, d1, d2}, nxt);
   endtask

   // static currents with opposite signs, open loop from reset
   task automatic sc_static();
      frame(`MDSR_ADDR_X_SET, `MDSR_ADDR_Y_SET, 32'h3d4ccccd, 32'hbda3d70a, 1'b1);
      chk("x setpoint", 32'h3d4ccccd, x_set);
      chk("y setpoint", 32'hbda3d70a, y_set);
   endtask

   // generator set up in the documented order
   task automatic sc_generator();
      frame(`MDSR_ADDR_X_SRC, `MDSR_ADDR_Y_SRC, `MDSR_SRC_X_GEN, `MDSR_SRC_Y_GEN, 1'b1);
      chk("gen sources", {`MDSR_SRCSEL_GEN, `MDSR_SRCSEL_GEN}, {x_src, y_src});
      frame(`MDSR_ADDR_X_MODE, `MDSR_ADDR_Y_MODE, `MDSR_MODE_X_CL, `MDSR_MODE_Y_OL, 1'b1);
      chk("modes", 2'h2, {x_cl, y_cl});
      frame(`MDSR_ADDR_X_UNIT, `MDSR_ADDR_Y_UNIT, `MDSR_UNIT_XY, `MDSR_UNIT_CURRENT, 1'b1);
      chk("units", 2'h2, {x_xy, y_xy});
      frame(`MDSR_ADDR_X_SHAPE, `MDSR_ADDR_Y_SHAPE, `MDSR_SHAPE_TRI, `MDSR_SHAPE_SIN, 1'b1);
      chk("shapes", 2'h2, {x_tri, y_tri});
      frame(`MDSR_ADDR_X_FREQ, `MDSR_ADDR_Y_FREQ, 32'h40a00000, 32'h41200000, 1'b1);
      chk("freqs", {32'h40a00000, 32'h41200000}, {x_frq, y_frq});
      frame(`MDSR_ADDR_X_AMP, `MDSR_ADDR_Y_AMP, 32'h3f19999a, 32'h3d4ccccd, 1'b1);
      chk("amps", {32'h3f19999a, 32'h3d4ccccd}, {x_amp, y_amp});
      frame(`MDSR_ADDR_X_RUN, `MDSR_ADDR_Y_RUN, `MDSR_RUN_ON, `MDSR_RUN_ON, 1'b1);
      chk("runs", 2'h3, {x_run, y_run});
      chk("setpoints kept", {32'h3d4ccccd, 32'hbda3d70a}, {x_set, y_set});
   endtask

   // analog sources, readback failing for the reply built now
   task automatic sc_analog();
      rb_ok = 1'b0;
      frame(`MDSR_ADDR_X_SRC, `MDSR_ADDR_Y_SRC, `MDSR_SRC_X_ANA, `MDSR_SRC_Y_ANA, 1'b1);
      chk("ana sources", {`MDSR_SRCSEL_ANALOG, `MDSR_SRCSEL_ANALOG}, {x_src, y_src});
   endtask

   // unmapped first address echoed as zero, second address still written
   task automatic sc_unmapped();
      rb_ok = 1'b1;
      frame(16'h1234, `MDSR_ADDR_Y_SET, 32'h3f800000, 32'h3e800000, 1'b0);
      chk("x setpoint kept", 32'h3d4ccccd, x_set);
      chk("y setpoint", 32'h3e800000, y_set);
      frame(`MDSR_ADDR_X_SHAPE, `MDSR_ADDR_Y_SHAPE, `MDSR_SHAPE_SIN, `MDSR_SHAPE_TRI, 1'b1);
      chk("shapes swapped", 2'h1, {x_tri, y_tri});
   endtask

   // reads: stored word comes back one frame later, unmapped read gives the fail code
   task automatic sc_read();
      xact({`MDSR_FLAG_READ, `MDSR_ADDR_X_SET, 80'h0}, {`MDSR_FLAG_READ, 32'h3d4ccccd, x_rb, y_rb});
      xact({`MDSR_FLAG_READ, 16'h1234, 80'h0}, {`MDSR_FLAG_READ, `MDSR_FAIL_DATA, x_rb, y_rb});
      chk("setpoints after reads", {32'h3d4ccccd, 32'h3e800000}, {x_set, y_set});
      frame(`MDSR_ADDR_X_SET, `MDSR_ADDR_Y_SET, 32'hbf800000, 32'h3f800000, 1'b1);
      chk("setpoints rewritten", {32'hbf800000, 32'h3f800000}, {x_set, y_set});
   endtask

   // main sequence
   initial
   begin
      failures  = 0;
      cmp_count = 0;
      rb_ok     = 1'b1;
      x_rb      = 32'h3e4ccccd;
      y_rb      = 32'hbe99999a;
      do_reset();
      sc_static();
      sc_generator();
      sc_analog();
      sc_unmapped();
      sc_read();
      do_reset();
      results();
   end
endmodule // tb
